// >>> include/smc_pkg.sv
// Package: register map, field layout and reset values of the serial mode block
package smc_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] ADDR_FRAME_SETUP = 12'hF63;
   localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hF66;
   localparam logic [11:0] ADDR_RELOAD_LOW  = 12'hF67;
   localparam logic [11:0] ADDR_STATUS      = 12'hF62;
   // ****************************************
   // Field positions of serial_frame_setup
   // ****************************************
   localparam int PEEK_BIT  = 5;
   localparam int LEN_HI    = 4;
   localparam int LEN_LO    = 2;
   localparam int DIR_BIT   = 1;
   localparam int LEVEL_BIT = 0;
   localparam logic [7:0] SETUP_WR_MASK = 8'h3F;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] SETUP_RESET  = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'hFF;
   localparam logic [2:0] LEN_CODE_8   = 3'h0;
   localparam logic [3:0] LEN_BITS_8   = 4'h8;
   // ****************************************
   // Status bit positions
   // ****************************************
   localparam int STAT_ACTIVE_BIT = 1;
   localparam int STAT_SEL_BIT    = 0;
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b01,
      RD_VALID = 2'b10
   } smc_rd_t;
endpackage

// >>> logic/smc_reload_reg.sv
// Module: one byte of the rate reload value with its software write port
`timescale 1ns/100ps
module smc_reload_reg (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Stored byte
   output logic [7:0]      value_r
);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         value_r <= smc_pkg::RELOAD_RESET;
      end else if (wr_en) begin
         value_r <= wr_data;
      end
   end
endmodule

// >>> logic/smc_len_decode.sv
// Module: character-length code to bit count, registered
`timescale 1ns/100ps
module smc_len_decode (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Length code
   input  wire logic [2:0] len_code,
   // Bits per character
   output logic [3:0]      bit_count_r
);
   wire logic [3:0] bit_count_nxt;
   // Code zero stands for a full byte
   assign bit_count_nxt = (len_code == smc_pkg::LEN_CODE_8) ? smc_pkg::LEN_BITS_8
                                                          : {1'b0, len_code};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_count_r <= smc_pkg::LEN_BITS_8;
      end else begin
         bit_count_r <= bit_count_nxt;
      end
   end
endmodule

// >>> logic/smc_mode_top.sv
// Module: mode register, reload bytes, counter peek and status of the serial unit
// Operation
// - One mode register sets character length and select pin direction and level.
// - Peek clear: reload locations read back stored reload bytes.
// - Peek set: reload locations read live counter high and low, unlatched.
// - Length code 000 means eight bits, 001 to 111 one to seven.
// - Direction bit zero: select pin is input, never driven.
// - Direction bit one: select pin driven, only while master.
// - Output and master: pin low for level 0, high for level 1.
// - Level bit ignored when pin is input or unit is slave.
// - Reload value is high byte over low byte, sixteen bits.
`timescale 1ns/100ps
module smc_mode_top (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Unit state
   input  wire logic        master_mode,
   input  wire logic        xfer_busy,
   input  wire logic [15:0] rate_count,
   // Select pin
   input  wire logic        sel_pin_in,
   output logic             sel_pin_out,
   output logic             sel_pin_oe_n,
   // Configuration to the shifter and rate generator
   output logic [3:0]       char_bits,
   output logic [15:0]      rate_reload
);
   // ****************************************
   // Register state
   // ****************************************
   logic [7:0]       serial_frame_setup_r;
   logic [7:0]       reload_high;
   logic [7:0]       reload_low;
   logic [7:0]       rdata_r;
   logic             sel_out_r;
   logic             sel_oe_n_r;
   logic [15:0]      reload_r;
   logic             sel_in_r;
   smc_pkg::smc_rd_t rd_state_r;
   // ****************************************
   // Address decode
   // ****************************************
   wire logic hit_setup;
   wire logic hit_high;
   wire logic hit_low;
   wire logic hit_status;
   wire logic wr_setup;
   wire logic wr_high;
   wire logic wr_low;
   assign hit_setup  = (reg_addr == smc_pkg::ADDR_FRAME_SETUP);
   assign hit_high   = (reg_addr == smc_pkg::ADDR_RELOAD_HIGH);
   assign hit_low    = (reg_addr == smc_pkg::ADDR_RELOAD_LOW);
   assign hit_status = (reg_addr == smc_pkg::ADDR_STATUS);
   assign wr_setup   = reg_wr && hit_setup;
   assign wr_high    = reg_wr && hit_high;
   assign wr_low     = reg_wr && hit_low;
   // ****************************************
   // Mode register
   // ****************************************
   wire logic       peek_en;
   wire logic [2:0] char_length_field;
   wire logic       select_pin_direction;
   wire logic       select_pin_level;
   assign peek_en              = serial_frame_setup_r[smc_pkg::PEEK_BIT];
   assign char_length_field    = serial_frame_setup_r[smc_pkg::LEN_HI:smc_pkg::LEN_LO];
   assign select_pin_direction = serial_frame_setup_r[smc_pkg::DIR_BIT];
   assign select_pin_level     = serial_frame_setup_r[smc_pkg::LEVEL_BIT];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_frame_setup_r <= smc_pkg::SETUP_RESET;
      end else if (wr_setup) begin
         // Top two bits are reserved and never stored
         serial_frame_setup_r <= reg_wdata & smc_pkg::SETUP_WR_MASK;
      end
   end
   // ****************************************
   // Reload bytes
   // ****************************************
   smc_reload_reg u_high (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr_en   (wr_high),
      .wr_data (reg_wdata),
      .value_r (reload_high)
   );
   smc_reload_reg u_low (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr_en   (wr_low),
      .wr_data (reg_wdata),
      .value_r (reload_low)
   );
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reload_r <= {smc_pkg::RELOAD_RESET, smc_pkg::RELOAD_RESET};
      end else begin
         reload_r <= {reload_high, reload_low};
      end
   end
   assign rate_reload = reload_r;
   // ****************************************
   // Character length
   // ****************************************
   smc_len_decode u_len (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .len_code    (char_length_field),
      .bit_count_r (char_bits)
   );
   // ****************************************
   // Select pin drive
   // ****************************************
   wire logic sel_drive;
   assign sel_drive = select_pin_direction && master_mode;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_oe_n_r <= 1'b1;
         sel_out_r  <= 1'b1;
      end else begin
         sel_oe_n_r <= !sel_drive;
         sel_out_r  <= sel_drive ? select_pin_level : 1'b1;
      end
   end
   assign sel_pin_out  = sel_out_r;
   assign sel_pin_oe_n = sel_oe_n_r;
   // ****************************************
   // Status
   // ****************************************
   // Outside slave operation the input reads as deasserted
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_in_r <= 1'b1;
      end else begin
         sel_in_r <= master_mode ? 1'b1 : sel_pin_in;
      end
   end
   // ****************************************
   // Read path
   // ****************************************
   // Counter bytes are taken live; a two-byte peek may straddle a carry
   wire logic [7:0] high_view;
   wire logic [7:0] low_view;
   wire logic [7:0] status_view;
   wire logic [7:0] rdata_nxt;
   assign high_view   = peek_en ? rate_count[15:8] : reload_high;
   assign low_view    = peek_en ? rate_count[7:0] : reload_low;
   assign status_view = {6'h00, xfer_busy, sel_in_r};
   assign rdata_nxt   = !reg_rd    ? 8'h00 :
                        hit_setup  ? serial_frame_setup_r :
                        hit_high   ? high_view :
                        hit_low    ? low_view :
                        hit_status ? status_view : 8'h00;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_r    <= 8'h00;
         rd_state_r <= smc_pkg::RD_IDLE;
      end else begin
         rdata_r    <= rdata_nxt;
         rd_state_r <= reg_rd ? smc_pkg::RD_VALID : smc_pkg::RD_IDLE;
      end
   end
   assign reg_rdata = rdata_r;
   // ****************************************
   // Checks
   // ****************************************
   sequence s_setup_write;
      wr_setup;
   endsequence
   a_reserved_bits_zero: assert property (@(posedge sys_clk) disable iff (rst)
      serial_frame_setup_r[7:6] == 2'b00)
      else $error("reserved mode bits not zero");
   a_setup_write_store: assert property (@(posedge sys_clk) disable iff (rst)
      s_setup_write |=> serial_frame_setup_r == ($past(reg_wdata) & smc_pkg::SETUP_WR_MASK))
      else $error("mode write not stored");
   a_peek_high_read: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && hit_high && peek_en) |=> reg_rdata == $past(rate_count[15:8]))
      else $error("peek high wrong");
   a_stored_low_read: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && hit_low && !peek_en) |=> reg_rdata == $past(reload_low))
      else $error("stored low wrong");
   a_len_decode_val: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 char_bits == (($past(char_length_field) == smc_pkg::LEN_CODE_8) ? smc_pkg::LEN_BITS_8
                        : {1'b0, $past(char_length_field)}))
      else $error("length decode wrong");
   a_pin_input_free: assert property (@(posedge sys_clk) disable iff (rst)
      !select_pin_direction |=> sel_pin_oe_n)
      else $error("select pin driven as input");
   a_pin_level_drive: assert property (@(posedge sys_clk) disable iff (rst)
      (select_pin_direction && master_mode) |=>
         (!sel_pin_oe_n && sel_pin_out == $past(select_pin_level)))
      else $error("select level wrong");
   a_slave_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
      !master_mode |=> sel_pin_oe_n)
      else $error("slave drives select pin");
   a_reload_join: assert property (@(posedge sys_clk) disable iff (rst)
      ##1 rate_reload == {$past(reload_high), $past(reload_low)})
      else $error("reload value wrong");
   a_status_busy_read: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && hit_status) |=> reg_rdata[1] == $past(xfer_busy))
      else $error("busy status wrong");
   // ****************************************
   // Checks: register port
   // ****************************************
   sequence s_read_high;
      reg_rd && hit_high;
   endsequence
   sequence s_read_low;
      reg_rd && hit_low;
   endsequence
   sequence s_read_setup;
      reg_rd && hit_setup;
   endsequence
   sequence s_read_status;
      reg_rd && hit_status;
   endsequence
   sequence s_unmapped_read;
      reg_rd && !hit_setup && !hit_high && !hit_low && !hit_status;
   endsequence
   sequence s_high_write;
      wr_high;
   endsequence
   sequence s_low_write;
      wr_low;
   endsequence
   a_stored_high_read: assert property (@(posedge sys_clk) disable iff (rst)
      (s_read_high ##0 !peek_en) |=> reg_rdata == $past(reload_high))
      else $error("stored high wrong");
   a_peek_low_read: assert property (@(posedge sys_clk) disable iff (rst)
      (s_read_low ##0 peek_en) |=> reg_rdata == $past(rate_count[7:0]))
      else $error("peek low wrong");
   a_setup_read_back: assert property (@(posedge sys_clk) disable iff (rst)
      s_read_setup |=> reg_rdata == $past(serial_frame_setup_r))
      else $error("mode read back wrong");
   a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
      s_unmapped_read |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // Read data must vanish after one cycle, or a slow master reads stale bytes
   a_idle_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (rd_state_r == smc_pkg::RD_IDLE) |-> reg_rdata == 8'h00)
      else $error("idle read data not zero");
   a_read_state_valid: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd |=> rd_state_r == smc_pkg::RD_VALID)
      else $error("read state not valid");
   a_setup_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !wr_setup |=> $stable(serial_frame_setup_r))
      else $error("mode changed without write");
   // ****************************************
   // Checks: reload bytes and length
   // ****************************************
   a_high_write_store: assert property (@(posedge sys_clk) disable iff (rst)
      s_high_write |=> reload_high == $past(reg_wdata))
      else $error("reload high not stored");
   a_low_write_store: assert property (@(posedge sys_clk) disable iff (rst)
      s_low_write |=> reload_low == $past(reg_wdata))
      else $error("reload low not stored");
   a_high_byte_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !wr_high |=> $stable(reload_high))
      else $error("reload high changed without write");
   a_low_byte_hold: assert property (@(posedge sys_clk) disable iff (rst)
      !wr_low |=> $stable(reload_low))
      else $error("reload low changed without write");
   a_len_in_range: assert property (@(posedge sys_clk) disable iff (rst)
      (char_bits >= 4'h1) && (char_bits <= smc_pkg::LEN_BITS_8))
      else $error("length out of range");
   a_len_full_byte: assert property (@(posedge sys_clk) disable iff (rst)
      (char_length_field == smc_pkg::LEN_CODE_8) |=> char_bits == smc_pkg::LEN_BITS_8)
      else $error("code zero not eight bits");
   // ****************************************
   // Checks: select pin and status
   // ****************************************
   sequence s_drive_on;
      select_pin_direction && master_mode;
   endsequence
   a_master_drive_on: assert property (@(posedge sys_clk) disable iff (rst)
      s_drive_on |=> !sel_pin_oe_n)
      else $error("master output not driven");
   a_drive_low_level: assert property (@(posedge sys_clk) disable iff (rst)
      (s_drive_on ##0 !select_pin_level) |=> !sel_pin_out)
      else $error("select not driven low");
   a_level_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      (!select_pin_direction || !master_mode) |=> sel_pin_oe_n)
      else $error("level applied while not driving");
   a_pin_high_undriven: assert property (@(posedge sys_clk) disable iff (rst)
      sel_pin_oe_n |-> sel_pin_out)
      else $error("undriven output not high");
   a_sel_in_slave: assert property (@(posedge sys_clk) disable iff (rst)
      !master_mode |=> sel_in_r == $past(sel_pin_in))
      else $error("select input not sampled");
   a_sel_in_master: assert property (@(posedge sys_clk) disable iff (rst)
      master_mode |=> sel_in_r)
      else $error("select input not idle as master");
   a_status_top_zero: assert property (@(posedge sys_clk) disable iff (rst)
      s_read_status |=> reg_rdata[7:2] == 6'h00)
      else $error("status upper bits not zero");
endmodule

// >>> sim/smc_far_side.sv
// Far-side model of the select line: external party plus line pull-up
`timescale 1ns/100ps
module smc_far_side (
   // Our side of the pad
   input  wire logic sel_pin_out,
   input  wire logic sel_pin_oe_n,
   // External party
   input  wire logic far_drive,
   input  wire logic far_level,
   // Resolved pad level
   output logic      sel_wire
);
   // Pull-up wins when nobody drives, so an undriven line never reads stale
   assign sel_wire = !sel_pin_oe_n ? sel_pin_out : (far_drive ? far_level : 1'b1);
endmodule

// >>> sim/smc_mode_top_tb_top.sv
// Testbench: self-checking random and corner tests of the serial mode block
`timescale 1ns/100ps
module smc_mode_top_tb_top;
   // ****************************************
   // Signals
   // ****************************************
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        master_mode = 1'b0;
   logic        xfer_busy = 1'b0;
   logic [15:0] rate_count = 16'h0000;
   logic        sel_wire;
   logic        sel_pin_out;
   logic        sel_pin_oe_n;
   logic [3:0]  char_bits;
   logic [15:0] rate_reload;
   logic        far_drive = 1'b0;
   logic        far_level = 1'b1;
   int          n_mismatch = 0;
   int          checked = 0;
   logic [31:0] seed;
   logic [7:0]  v, h, l;
   logic [15:0] cnt;
   always #4 sys_clk = ~sys_clk;
   smc_mode_top smc_mode_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .master_mode(master_mode), .xfer_busy(xfer_busy), .rate_count(rate_count),
      .sel_pin_in(sel_wire), .sel_pin_out(sel_pin_out), .sel_pin_oe_n(sel_pin_oe_n),
      .char_bits(char_bits), .rate_reload(rate_reload));
   smc_far_side smc_far_side_inst (.sel_pin_out(sel_pin_out), .sel_pin_oe_n(sel_pin_oe_n),
      .far_drive(far_drive), .far_level(far_level), .sel_wire(sel_wire));
   // ****************************************
   // Compare, bus and closing tasks
   // ****************************************
   task automatic chk_out(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand one cycle only, so the idle zero is checked as well
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      checked++;
      if (reg_rdata !== exp) begin
         n_mismatch++;
         $display("[FAIL] reg_rdata at %h expected %h seen %h", a, exp, reg_rdata);
      end
      @(posedge sys_clk);
      #1;
      chk_out("reg_rdata idle", 16'h0000, {8'h00, reg_rdata});
   endtask
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [15:0] exp_bits(input logic [2:0] c);
      return (c == 3'h0) ? 16'h0008 : {13'h0000, c};
   endfunction
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = $urandom(32'h06CE6651);
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      settle();
      chk_out("char_bits", 16'h0008, {12'h000, char_bits});
      chk_out("sel_pin_oe_n", 16'h0001, {15'h0000, sel_pin_oe_n});
      chk_out("rate_reload", 16'hFFFF, rate_reload);
      rd_chk(smc_pkg::ADDR_FRAME_SETUP, 8'h00);
      rd_chk(smc_pkg::ADDR_RELOAD_LOW, 8'hFF);
      // Reserved bits written as ones on purpose to see them refused
      v = $urandom;
      wr(smc_pkg::ADDR_FRAME_SETUP, v | 8'hC0);
      rd_chk(smc_pkg::ADDR_FRAME_SETUP, v & 8'h3F);
      for (int i = 0; i < 8; i++) begin
         wr(smc_pkg::ADDR_FRAME_SETUP, {3'h0, 3'(i), 2'h0});
         settle();
         chk_out("char_bits", exp_bits(3'(i)), {12'h000, char_bits});
      end
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         master_mode <= k[2];
         xfer_busy <= $urandom;
         far_drive <= ~k[2];
         far_level <= $urandom;
         wr(smc_pkg::ADDR_FRAME_SETUP, {6'h00, k[1], k[0]});
         settle();
         chk_out("sel_pin_oe_n", {15'h0000, ~(k[1] & k[2])}, {15'h0000, sel_pin_oe_n});
         chk_out("sel_pin_out", {15'h0000, ~(k[1] & k[2]) | k[0]}, {15'h0000, sel_pin_out});
         rd_chk(smc_pkg::ADDR_STATUS, {6'h00, xfer_busy, k[2] | far_level});
      end
      h = $urandom;
      l = $urandom;
      wr(smc_pkg::ADDR_RELOAD_HIGH, h);
      wr(smc_pkg::ADDR_RELOAD_LOW, l);
      rd_chk(smc_pkg::ADDR_RELOAD_HIGH, h);
      rd_chk(smc_pkg::ADDR_RELOAD_LOW, l);
      settle();
      chk_out("rate_reload", {h, l}, rate_reload);
      wr(smc_pkg::ADDR_FRAME_SETUP, 8'h20);
      // Counter held still across each single read, changed between reads
      for (int j = 0; j < 4; j++) begin
         cnt = $urandom;
         rate_count <= cnt;
         rd_chk(smc_pkg::ADDR_RELOAD_HIGH, cnt[15:8]);
         cnt = ~cnt;
         rate_count <= cnt;
         rd_chk(smc_pkg::ADDR_RELOAD_LOW, cnt[7:0]);
      end
      wr(smc_pkg::ADDR_FRAME_SETUP, 8'h00);
      rd_chk(smc_pkg::ADDR_RELOAD_HIGH, h);
      wr(12'hF65, 8'hA5);
      rd_chk(12'hF65, 8'h00);
      rd_chk(smc_pkg::ADDR_RELOAD_LOW, l);
      // Second reset in mid-run
      wr(smc_pkg::ADDR_FRAME_SETUP, 8'h1F);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(smc_pkg::ADDR_FRAME_SETUP, 8'h00);
      chk_out("char_bits", 16'h0008, {12'h000, char_bits});
      chk_out("sel_pin_oe_n", 16'h0001, {15'h0000, sel_pin_oe_n});
      chk_out("sel_pin_out", 16'h0001, {15'h0000, sel_pin_out});
      chk_out("rate_reload", 16'hFFFF, rate_reload);
      print_verdict();
   end
endmodule
